// ==== hdl/arp_defs.svh ====
// constants for the converter result readout port
// assumes inclusion by bare name from hdl/
`ifndef ARP_DEFS_SVH
`define ARP_DEFS_SVH
`define ARP_WORD_W 16
`define ARP_BITS 5'h10
`define ARP_LAST_BIT 5'h0F
`define ARP_CLK_MHZ 40
`define ARP_CONV_NS 8000
`define ARP_SCLK_HALF_NS 50
`define ARP_NPINS 9
`define ARP_PIN_CS 0
`define ARP_PIN_RD 1
`define ARP_PIN_CNV 2
`define ARP_PIN_SER 3
`define ARP_PIN_EXT 4
`define ARP_PIN_OB 5
`define ARP_PIN_RDC 6
`define ARP_PIN_INVF 7
`define ARP_PIN_INVC 8
`define ARP_SYNC_RST 9'h007
`endif

// ==== hdl/arp_pkg.sv ====
// types for the converter result readout port
// assumes nothing of its surroundings
package arp_pkg;
  typedef enum logic [0:0] {
    M_IDLE,
    M_SHIFT
  } arp_mstate_type;
endpackage

// ==== hdl/arp_readout.sv ====
// result readout port: parallel bus, master serial, slave serial
// assumes conv_data_i comes from the converter core on clk_i
`include "arp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - data and serial result outputs float whenever chip select or read strobe is high; master serial clock stays driven
// - coding select picks two's complement or straight binary
// - parallel result readable after conversion or during next one
// - serial result is 16 bits, MSB first, one bit per clock
// - clock source select low makes the device serial master
// - master drives a frame signal; frame and clock polarity invertible
// - master data held over a whole clock period, valid on both edges
// - read timing select picks master shift after or during conversion
// - master read-after keeps busy high until 16 bits are out
// - clock source select high makes the device shift on host clock
// - slave accepts continuous or gated clock while selected
// - slave read-after: new result out MSB first after busy falls
// - slave read-after accepts host clock up to its maximum rate
// - slave read-after uses read timing pin as daisy-chain input
// - chain input latched on opposite edge; upstream MSB follows LSB
// - daisy chain of up to twenty converters, shared convert start
// - slave read-during: overrun flag pulses if bits not all taken
// - slow hosts read after conversion, byte by byte
// - falling convert start begins conversion; busy high until done
module arp_readout #(
  parameter int CONV_NS = `ARP_CONV_NS,
  parameter int SCLK_HALF_NS = `ARP_SCLK_HALF_NS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sclk_ext_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic convert_start_n_i,
  input wire logic serial_parallel_select_i,
  input wire logic clock_source_select_i,
  input wire logic output_coding_select_i,
  input wire logic read_timing_chain_in_i,
  input wire logic frame_polarity_invert_i,
  input wire logic serial_clock_invert_i,
  input wire logic [`ARP_WORD_W-1:0] conv_data_i,
  output logic [`ARP_WORD_W-1:0] data_o,
  output logic data_oe_o,
  output logic busy_o,
  output logic serial_result_out_o,
  output logic serial_result_oe_o,
  output logic serial_clock_o,
  output logic serial_clock_oe_o,
  output logic frame_sync_o,
  output logic read_overrun_flag_o
);
  localparam int CONV_CYC = CONV_NS * `ARP_CLK_MHZ / 1000;
  localparam int HALF_CYC = (SCLK_HALF_NS * `ARP_CLK_MHZ + 999) / 1000;
  localparam logic [15:0] CONV_LAST = 16'(CONV_CYC - 1);
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [`ARP_NPINS-1:0] pin_raw;
  logic [`ARP_NPINS-1:0] pin_meta_reg;
  logic [`ARP_NPINS-1:0] pin_reg;
  assign pin_raw = {serial_clock_invert_i, frame_polarity_invert_i,
    read_timing_chain_in_i, output_coding_select_i,
    clock_source_select_i, serial_parallel_select_i,
    convert_start_n_i, rd_n_i, cs_n_i};
  genvar gi;
  generate
    for (gi = 0; gi < `ARP_NPINS; gi++) begin : g_sync
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          pin_meta_reg[gi] <= 1'(`ARP_SYNC_RST >> gi);
          pin_reg[gi] <= 1'(`ARP_SYNC_RST >> gi);
        end else if (ce_i) begin
          pin_meta_reg[gi] <= pin_raw[gi];
          pin_reg[gi] <= pin_meta_reg[gi];
        end
      end
    end
  endgenerate

  logic sel_s;
  logic ser_s;
  logic master_s;
  logic during_s;
  assign sel_s = ~(pin_reg[`ARP_PIN_CS] | pin_reg[`ARP_PIN_RD]);
  assign ser_s = pin_reg[`ARP_PIN_SER];
  assign master_s = ser_s & ~pin_reg[`ARP_PIN_EXT];
  assign during_s = pin_reg[`ARP_PIN_RDC];

  // ****************************************
  // conversion timing
  // ****************************************
  logic cnv_prev_reg;
  logic converting_reg;
  logic conv_end_reg;
  logic [15:0] conv_cnt_reg;
  logic [`ARP_WORD_W-1:0] result_reg;
  logic start_conv;
  logic busy_next;
  arp_pkg::arp_mstate_type mst_reg;
  assign start_conv = cnv_prev_reg & ~pin_reg[`ARP_PIN_CNV] & ~busy_o;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnv_prev_reg <= 1'b1;
      converting_reg <= 1'b0;
      conv_end_reg <= 1'b0;
      conv_cnt_reg <= 16'h0000;
      result_reg <= 16'h0000;
    end else if (ce_i) begin
      cnv_prev_reg <= pin_reg[`ARP_PIN_CNV];
      conv_end_reg <= 1'b0;
      if (start_conv) begin
        converting_reg <= 1'b1;
        conv_cnt_reg <= 16'h0000;
      end else if (converting_reg) begin
        if (conv_cnt_reg == CONV_LAST) begin
          converting_reg <= 1'b0;
          conv_end_reg <= 1'b1;
          result_reg <= conv_data_i;
        end else begin
          conv_cnt_reg <= conv_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // output coding, identical for all paths
  logic [`ARP_WORD_W-1:0] coded;
  always_comb begin
    coded = result_reg;
    if (!pin_reg[`ARP_PIN_OB]) begin
      coded[`ARP_WORD_W-1] = ~result_reg[`ARP_WORD_W-1];
    end
  end

  // ****************************************
  // parallel bus
  // ****************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_o <= 16'h0000;
      data_oe_o <= 1'b0;
    end else if (ce_i) begin
      data_o <= coded;
      data_oe_o <= sel_s & ~ser_s;
    end
  end

  // ****************************************
  // master serial engine
  // ****************************************
  logic [7:0] half_cnt_reg;
  logic [4:0] mbit_reg;
  logic msclk_reg;
  logic mdata_reg;
  logic [`ARP_WORD_W-1:0] mshift_reg;
  logic mstart;
  assign mstart = master_s & (during_s ? start_conv : conv_end_reg);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mst_reg <= arp_pkg::M_IDLE;
      half_cnt_reg <= 8'h00;
      mbit_reg <= 5'h00;
      msclk_reg <= 1'b0;
      mdata_reg <= 1'b0;
      mshift_reg <= 16'h0000;
    end else if (ce_i) begin
      unique case (mst_reg)
        arp_pkg::M_IDLE: begin
          msclk_reg <= 1'b0;
          if (mstart) begin
            mst_reg <= arp_pkg::M_SHIFT;
            mdata_reg <= coded[`ARP_WORD_W-1];
            mshift_reg <= {coded[`ARP_WORD_W-2:0], 1'b0};
            half_cnt_reg <= 8'h00;
            mbit_reg <= 5'h00;
          end
        end
        arp_pkg::M_SHIFT: begin
          if (half_cnt_reg == HALF_LAST) begin
            half_cnt_reg <= 8'h00;
            msclk_reg <= ~msclk_reg;
            // data changes only as the clock falls: stable across the rise
            if (msclk_reg) begin
              if (mbit_reg == `ARP_LAST_BIT) begin
                mst_reg <= arp_pkg::M_IDLE;
              end else begin
                mbit_reg <= mbit_reg + 5'h01;
                mdata_reg <= mshift_reg[`ARP_WORD_W-1];
                mshift_reg <= {mshift_reg[`ARP_WORD_W-2:0], 1'b0};
              end
            end
          end else begin
            half_cnt_reg <= half_cnt_reg + 8'h01;
          end
        end
      endcase
    end
  end

  // master clock and frame take polarity on the way out; serial data does not
  logic mshifting;
  logic [1:0] mdata_pipe_reg;
  assign mshifting = (mst_reg == arp_pkg::M_SHIFT);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mdata_pipe_reg <= 2'h0;
      serial_clock_o <= 1'b0;
      serial_clock_oe_o <= 1'b0;
      frame_sync_o <= 1'b0;
    end else if (ce_i) begin
      mdata_pipe_reg <= {mdata_pipe_reg[0], mdata_reg}; // moves a cycle after clock falls
      serial_clock_o <= msclk_reg ^ pin_reg[`ARP_PIN_INVC];
      serial_clock_oe_o <= master_s;
      frame_sync_o <= (mshifting & master_s) ^ pin_reg[`ARP_PIN_INVF];
    end
  end

  // ****************************************
  // slave serial engine on the host clock
  // ****************************************
  logic lk_arst;
  logic [4:0] lk_cnt_reg;
  logic [`ARP_WORD_W-1:0] lk_shift_reg;
  logic lk_out_reg;
  logic lk_chain_reg;
  logic lk_done_tgl_reg;
  // frame end clears the bit count; the host clock may stop at any time
  assign lk_arst = rst_i | cs_n_i | rd_n_i;

  always_ff @(posedge sclk_ext_i or posedge lk_arst) begin
    if (lk_arst) begin
      lk_cnt_reg <= 5'h00;
    end else if (lk_cnt_reg != `ARP_BITS) begin
      lk_cnt_reg <= lk_cnt_reg + 5'h01;
    end
  end

  // result word is quiet while the host shifts, so it is read directly
  always_ff @(posedge sclk_ext_i or posedge rst_i) begin
    if (rst_i) begin
      lk_out_reg <= 1'b0;
      lk_shift_reg <= 16'h0000;
    end else if (lk_cnt_reg == 5'h00) begin
      lk_out_reg <= coded[`ARP_WORD_W-1];
      lk_shift_reg <= coded;
    end else begin
      lk_out_reg <= lk_shift_reg[`ARP_WORD_W-2];
      lk_shift_reg <= {lk_shift_reg[`ARP_WORD_W-2:0], lk_chain_reg};
    end
  end

  always_ff @(negedge sclk_ext_i or posedge rst_i) begin
    if (rst_i) begin
      lk_chain_reg <= 1'b0;
    end else begin
      lk_chain_reg <= read_timing_chain_in_i;
    end
  end

  always_ff @(posedge sclk_ext_i or posedge rst_i) begin
    if (rst_i) begin
      lk_done_tgl_reg <= 1'b0;
    end else if (lk_cnt_reg == `ARP_LAST_BIT) begin
      lk_done_tgl_reg <= ~lk_done_tgl_reg;
    end
  end

  // ****************************************
  // read completion crossing and overrun
  // ****************************************
  logic done_meta_reg;
  logic done_s_reg;
  logic done_d_reg;
  logic rd_started_reg;
  logic rd_done_reg;
  logic done_pulse;
  assign done_pulse = done_s_reg ^ done_d_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_meta_reg <= 1'b0;
      done_s_reg <= 1'b0;
      done_d_reg <= 1'b0;
      rd_started_reg <= 1'b0;
      rd_done_reg <= 1'b0;
      read_overrun_flag_o <= 1'b0;
    end else if (ce_i) begin
      done_meta_reg <= lk_done_tgl_reg;
      done_s_reg <= done_meta_reg;
      done_d_reg <= done_s_reg;
      read_overrun_flag_o <= 1'b0;
      if (start_conv) begin
        rd_started_reg <= 1'b0;
        rd_done_reg <= 1'b0;
      end else if (converting_reg) begin
        if (sel_s & ser_s & ~master_s) begin
          rd_started_reg <= 1'b1;
        end
        if (done_pulse) begin
          rd_done_reg <= 1'b1;
        end
      end
      if (conv_end_reg & rd_started_reg & ~rd_done_reg) begin
        read_overrun_flag_o <= 1'b1;
      end
    end
  end

  // ****************************************
  // busy and serial output pin
  // ****************************************
  assign busy_next = start_conv | (converting_reg & ~conv_end_reg) |
    (master_s & ~during_s & (mstart | mshifting));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      serial_result_oe_o <= 1'b0;
    end else if (ce_i) begin
      busy_o <= busy_next;
      serial_result_oe_o <= sel_s & ser_s;
    end
  end

  // pin source follows the strapped mode; each source is a flop
  assign serial_result_out_o = master_s ? mdata_pipe_reg[1] : lk_out_reg;
endmodule
`default_nettype wire

// ==== verif/arp_readout_checker.sv ====
// checker: pin relations of the result readout port
// assumes binding into arp_readout; one clk_i domain
`timescale 1ns/1ps
`default_nettype none
module arp_readout_checker #(
  parameter int CONV_NS = 8000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic convert_start_n_i,
  input wire logic serial_parallel_select_i,
  input wire logic clock_source_select_i,
  input wire logic read_timing_chain_in_i,
  input wire logic frame_polarity_invert_i,
  input wire logic serial_clock_invert_i,
  input wire logic data_oe_o,
  input wire logic busy_o,
  input wire logic serial_result_out_o,
  input wire logic serial_result_oe_o,
  input wire logic serial_clock_o,
  input wire logic serial_clock_oe_o,
  input wire logic frame_sync_o,
  input wire logic read_overrun_flag_o
);
  // ********
  // checks
  // ********
  localparam int CC = CONV_NS / 25;
  int unsigned bcnt;
  int unsigned fcnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles spent busy and in frame
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) bcnt <= 0;
    else bcnt <= busy_o ? bcnt + 1 : 0;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) fcnt <= 0;
    else fcnt <= frame_sync_o ? fcnt + 1 : 0;
  end
  float_out_a: assert property ((cs_n_i || rd_n_i)[*5]
    |-> !data_oe_o && !serial_result_oe_o) else $error("driven while deselected");
  busy_start_a: assert property ($fell(convert_start_n_i) && !busy_o
    |-> ##[1:4] busy_o) else $error("busy late");
  busy_len_a: assert property ($fell(busy_o) && !(serial_parallel_select_i
    && !clock_source_select_i && !read_timing_chain_in_i) |-> bcnt inside {[CC:CC + 2]})
    else $error("busy length");
  busy_ext_a: assert property ($fell(busy_o) && serial_parallel_select_i
    && !clock_source_select_i && !read_timing_chain_in_i |-> bcnt >= CC + 62)
    else $error("busy ended before shift");
  frame_len_a: assert property ($fell(frame_sync_o) && !frame_polarity_invert_i
    |-> fcnt inside {[63:65]}) else $error("frame length");
  clk_stable_a: assert property ($rose(serial_clock_o) && frame_sync_o
    && !(frame_polarity_invert_i || serial_clock_invert_i || clock_source_select_i)
    |-> $stable(serial_result_out_o)) else $error("data moved at clock rise");
  clk_hold_a: assert property ($fell(serial_clock_o) && frame_sync_o
    && !(frame_polarity_invert_i || serial_clock_invert_i || clock_source_select_i)
    |-> serial_result_out_o == $past(serial_result_out_o, 2))
    else $error("data moved before clock fall");
  clk_drive_a: assert property ((serial_parallel_select_i
    && $stable(clock_source_select_i))[*5] |-> serial_clock_oe_o == !clock_source_select_i)
    else $error("clock drive");
  ovr_pulse_a: assert property (read_overrun_flag_o
    |-> clock_source_select_i ##1 !read_overrun_flag_o) else $error("overrun pulse");
  cover property ($fell(frame_sync_o));
  cover property ($rose(read_overrun_flag_o));
  cover property ($fell(busy_o) && clock_source_select_i);
endmodule
bind arp_readout arp_readout_checker #(.CONV_NS(CONV_NS)) arp_readout_checker_i (.*);
`default_nettype wire

// ==== verif/arp_host.sv ====
// host serial port model: gated link clock, upstream chain converter
// assumes the bench selects the device around each burst
`timescale 1ns/1ps
`default_nettype none
module arp_host (
  input wire logic sdo_i,
  output logic sclk_o,
  output logic chain_o
);
  // ********
  // link side
  // ********
  logic [15:0] up_word = 16'h0000;
  logic [15:0] up = 16'h0000;
  logic [31:0] cap = 32'h0000_0000;
  logic chain_en = 1'b0, strap = 1'b0, ch = 1'b0;
  initial sclk_o = 1'b0;
  assign chain_o = chain_en ? ch : strap;
  always @(posedge sclk_o) begin
    ch <= up[15];
    up <= {up[14:0], 1'b0};
  end
  task automatic park(input logic lvl);
    sclk_o = lvl;
  endtask
  task automatic burst(input int n, input logic hi);
    up = up_word;
    cap = 32'h0000_0000;
    #7;
    for (int i = 0; i < n; i++) begin
      sclk_o = !hi;
      #40;
      if (!hi) cap = {cap[30:0], sdo_i};
      sclk_o = hi;
      #40;
      if (hi) cap = {cap[30:0], sdo_i};
    end
  endtask
endmodule
`default_nettype wire

// ==== verif/arp_readout_tb.sv ====
// self-checking bench for the result readout port
// assumes arp_host models the serial host; ce_i held high
`timescale 1ns/1ps
`default_nettype none
module arp_readout_tb;
  // ********
  // bench
  // ********
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_n = 1'b1, rd_n = 1'b1, cnv_n = 1'b1, sps = 1'b0, css = 1'b0, ocs = 1'b1, inv = 1'b0;
  logic [15:0] cdata = 16'h0000;
  logic [15:0] dout, w;
  logic doe, busy, sdo, sclk, frame, ovr_o, xclk, chain, ck, soe, coe;
  int fail_count = 0, samples_checked = 0, ovr = 0;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (ovr_o === 1'b1) ovr++;
  arp_readout #(.CONV_NS(4000)) arp_readout_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .sclk_ext_i(xclk), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .convert_start_n_i(cnv_n), .serial_parallel_select_i(sps), .clock_source_select_i(css),
    .output_coding_select_i(ocs), .read_timing_chain_in_i(chain), .frame_polarity_invert_i(inv),
    .serial_clock_invert_i(inv), .conv_data_i(cdata), .data_o(dout), .data_oe_o(doe),
    .busy_o(busy), .serial_result_out_o(sdo), .serial_result_oe_o(soe), .serial_clock_o(sclk),
    .serial_clock_oe_o(coe), .frame_sync_o(frame), .read_overrun_flag_o(ovr_o));
  arp_host arp_host_i (.sdo_i(sdo), .sclk_o(xclk), .chain_o(chain));
  task automatic final_report();
    $display("counts: %0d checked, %0d mismatches", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (e !== g) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [15:0] code(input logic [15:0] d);
    return ocs ? d : {~d[15], d[14:0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic start(input logic [15:0] d);
    int k = 0;
    cdata <= d;
    cnv_n <= 1'b0;
    while (busy !== 1'b1 && k < 50) begin
      tick(1);
      k++;
    end
    cnv_n <= 1'b1;
  endtask
  task automatic idle();
    int k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      tick(1);
      k++;
    end
    tick(4);
  endtask
  task automatic resel(input logic lvl);
    tick(1);
    cs_n <= 1'b1;
    tick(2);
    arp_host_i.park(lvl);
    tick(2);
  endtask
  task automatic grab(input int n, input logic hi);
    cs_n <= 1'b0;
    tick(2);
    arp_host_i.burst(n, hi);
  endtask
  // master frame capture on rising serial clock
  task automatic mcap();
    logic p = 1'b0;
    int n = 0;
    int k = 0;
    w = 16'h0000;
    while (n < 16 && k < 2000) begin
      @(negedge clk_i);
      k++;
      if (frame && sclk && !p) begin
        w = {w[14:0], sdo};
        n++;
      end
      p = sclk;
    end
  endtask
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
  initial begin
    tick(16);
    rst_i <= 1'b0;
    tick(4);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    start(16'hA5C3);
    idle();
    chk("data", code(16'hA5C3), dout);
    chk("data_oe", 1'b1, doe);
    ocs <= 1'b0;
    start(16'h1234);
    tick(8);
    chk("data", code(16'hA5C3), dout);
    idle();
    chk("data", code(16'h1234), dout);
    rd_n <= 1'b1;
    tick(5);
    chk("data_oe", 1'b0, doe);
    rd_n <= 1'b0;
    cs_n <= 1'b1;
    tick(5);
    chk("data_oe", 1'b0, doe);
    $display("test parallel done");
    sps <= 1'b1;
    cs_n <= 1'b0;
    ocs <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      arp_host_i.strap <= m[0];
      tick(5);
      cdata <= 16'hC35A + m[15:0];
      cnv_n <= 1'b0;
      mcap();
      chk("master", 16'hC35A, w);
      chk("sclk_oe", 1'b1, coe);
      chk("sdo_oe", 1'b1, soe);
      idle();
      cnv_n <= 1'b1;
    end
    ck = sclk;
    inv <= 1'b1;
    tick(5);
    chk("frame", 1'b1, frame);
    chk("sclk", !ck, sclk);
    $display("test master done");
    css <= 1'b1;
    ocs <= 1'b0;
    arp_host_i.chain_en <= 1'b1;
    arp_host_i.up_word <= 16'h9A6B;
    resel(1'b0);
    chk("sdo_oe", 1'b0, soe);
    chk("sclk_oe", 1'b0, coe);
    start(16'h1357);
    idle();
    grab(32, 1'b0);
    chk("chain", {code(16'h1357), 16'h9A6B}, arp_host_i.cap);
    resel(1'b1);
    start(16'h2468);
    idle();
    grab(16, 1'b1);
    chk("slave", {16'h0000, code(16'h2468)}, arp_host_i.cap);
    chk("sdo_oe", 1'b1, soe);
    resel(1'b0);
    arp_host_i.chain_en <= 1'b0;
    start(16'h0001);
    grab(8, 1'b0);
    idle();
    chk("overrun", 1, ovr);
    resel(1'b0);
    start(16'h0002);
    grab(16, 1'b0);
    idle();
    chk("during", {16'h0000, code(16'h0001)}, arp_host_i.cap);
    chk("overrun", 1, ovr);
    $display("test slave done");
    final_report();
  end
endmodule
`default_nettype wire
